// ---- nabc_exec.sv ----
// Decoder and executor for arithmetic, logic, bit and compare words
`timescale 1ns/1ps
module nabc_exec
  import nabc_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               ins_valid,
  input  wire logic [INS_W-1:0]   ins_word,
  input  wire logic [NIB_W-1:0]   mem_rdata,
  output nabc_regs_s              regs,
  output nabc_mem_wr_s            mem_wr,
  output logic                    skip_next
);
  nabc_regs_s  regs_q, regs_d;   // Work register and carry flag
  nabc_state_e state_q, state_d; // Waiting for second compare word
  logic        skip_q, skip_d;   // Next word must be discarded
  nabc_mem_wr_s wr_d;            // Write to pointed nibble this cycle
  logic [3:0]  add_b;            // Second adder operand
  logic        add_ci;           // Adder carry in
  logic [3:0]  add_sum;          // Adder result
  logic        add_co;           // Adder carry out, overflow of the add words
  logic [3:0]  mem_op;           // Pointed nibble with any pending write forwarded
  logic        exec;             // Word is really executed
  logic [1:0]  bit_j;            // Bit select of bit words
  logic [3:0]  imm_n;            // Immediate field

  // Operand fields of the word
  assign bit_j = ins_word[1:0];
  assign imm_n = ins_word[3:0];
  assign exec  = ins_valid && !skip_q;
  // A bit write issued last cycle has not reached the RAM yet, so a word right
  // behind it would read a stale nibble; forward the pending data instead
  assign mem_op = mem_wr.we ? mem_wr.data : mem_rdata;

  // Adder operand select: immediate for add-immediate, else memory
  always_comb begin
    add_b  = mem_op;
    add_ci = 1'b0;
    if (ins_word[9:4] == GRP_ADD_IMM) begin
      add_b = imm_n;
    end else if (ins_word == OP_ADD_MEM_CY) begin
      add_ci = regs_q.carry;
    end
  end

  // One adder serves add memory, add with carry and add immediate
  nabc_adder #(.W(NIB_W)) nabc_adder_i (
    .a   (regs_q.work),
    .b   (add_b),
    .cin (add_ci),
    .sum (add_sum),
    .cout(add_co)
  );

  // Decode and compute next register, skip and memory write
  always_comb begin
    regs_d  = regs_q;
    state_d = state_q;
    skip_d  = skip_q;
    wr_d    = '{we: 1'b0, data: mem_op};
    if (ins_valid) begin
      skip_d = 1'b0;
      if (skip_q) begin
        // Discarded word: the skip flag clears and the state returns to fetch
        state_d = NABC_ST_FETCH;
      end else if (state_q == NABC_ST_SECOND) begin
        state_d = NABC_ST_FETCH;
        // Second word carries n; a malformed word compares nothing
        if (ins_word[9:4] == GRP_EQ_K2) begin
          skip_d = (regs_q.work == imm_n);
        end
      end else if (ins_word[9:4] == GRP_ADD_IMM) begin
        regs_d.work = add_sum;
        skip_d      = !add_co;
      end else if (ins_word[9:2] == GRP_SET_BIT) begin
        wr_d.we           = 1'b1;
        wr_d.data[bit_j]  = 1'b1;
      end else if (ins_word[9:2] == GRP_CLR_BIT) begin
        wr_d.we           = 1'b1;
        wr_d.data[bit_j]  = 1'b0;
      end else if (ins_word[9:2] == GRP_SKIP_BIT) begin
        skip_d = !mem_op[bit_j];
      end else begin
        unique case (ins_word)
          OP_ADD_MEM:     regs_d.work = add_sum;
          OP_ADD_MEM_CY: begin
            regs_d.work  = add_sum;
            regs_d.carry = add_co;
          end
          OP_AND_MEM:     regs_d.work = regs_q.work & mem_op;
          OP_OR_MEM:      regs_d.work = regs_q.work | mem_op;
          OP_SET_CY:      regs_d.carry = 1'b1;
          OP_CLR_CY:      regs_d.carry = 1'b0;
          OP_SKIP_CY_CLR: skip_d = !regs_q.carry;
          OP_CPL_WORK:    regs_d.work = ~regs_q.work;
          OP_ROT_RIGHT: begin
            regs_d.work  = {regs_q.carry, regs_q.work[3:1]};
            regs_d.carry = regs_q.work[0];
          end
          OP_SKIP_EQ_MEM: skip_d = (regs_q.work == mem_op);
          OP_SKIP_EQ_K1:  state_d = NABC_ST_SECOND;
          // Words of other blocks leave this state alone
          default: regs_d = regs_q;
        endcase
      end
    end
  end

  // Register stage; memory write is registered data, one cycle late
  always_ff @(posedge clk_sys) begin
    // Reset drops the write strobe so no stray write follows reset
    if (reset) begin
      regs_q  <= '{work: WORK_RESET, carry: CY_RESET};
      state_q <= NABC_ST_FETCH;
      skip_q  <= 1'b0;
      mem_wr  <= '{we: 1'b0, data: WORK_RESET};
    end else begin
      regs_q  <= regs_d;
      state_q <= state_d;
      skip_q  <= skip_d;
      mem_wr  <= wr_d;
    end
  end

  // Outputs come straight from the flops
  assign regs      = regs_q;
  assign skip_next = skip_q;

  // Checks look one edge after the word, where the registered answer stands;
  // exec already drops skipped words, so each check but a_skip_noop sees executed words only
  // Compare with a constant: the first word arms, a later word carries n
  sequence s_eq_first;
    exec && state_q == NABC_ST_FETCH && ins_word == OP_SKIP_EQ_K1;
  endsequence
  sequence s_eq_second;
    exec && state_q == NABC_ST_SECOND && ins_word[9:4] == GRP_EQ_K2;
  endsequence
  a_add_keeps_cy: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH && ins_word == OP_ADD_MEM |=>
    regs_q.work == 4'($past(regs_q.work) + $past(mem_op)) && $stable(regs_q.carry))
    else $error("add memory wrong");
  a_cpl_work: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH && ins_word == OP_CPL_WORK |=>
    regs_q.work == ~$past(regs_q.work))
    else $error("complement wrong");
  a_skip_cy: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH && ins_word == OP_SKIP_CY_CLR |=>
    skip_q == !$past(regs_q.carry) && $stable(regs_q.carry))
    else $error("carry skip wrong");
  a_skip_noop: assert property (@(posedge clk_sys) disable iff (reset)
    ins_valid && skip_q |=> $stable(regs_q) && !mem_wr.we && !skip_q)
    else $error("skipped word had effect");
  a_set_bit: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH && ins_word[9:2] == GRP_SET_BIT |=>
    mem_wr.we && mem_wr.data[$past(bit_j)])
    else $error("set bit wrong");
  a_clr_bit: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH && ins_word[9:2] == GRP_CLR_BIT |=>
    mem_wr.we && !mem_wr.data[$past(bit_j)])
    else $error("clear bit wrong");
  a_eq_mem: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH && ins_word == OP_SKIP_EQ_MEM |=>
    skip_q == ($past(regs_q.work) == $past(mem_op)))
    else $error("equal memory skip wrong");
  a_rot_right: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH && ins_word == OP_ROT_RIGHT |=>
    regs_q.carry == $past(regs_q.work[0]) && regs_q.work[3] == $past(regs_q.carry))
    else $error("rotate wrong");
  a_two_word: assert property (@(posedge clk_sys) disable iff (reset)
    s_eq_first |=>
    state_q == NABC_ST_SECOND && !skip_q)
    else $error("compare const first word wrong");
  // Second compare word decides the skip and returns to fetch
  a_eq_const: assert property (@(posedge clk_sys) disable iff (reset)
    s_eq_second |=>
    skip_q == ($past(regs_q.work) == $past(imm_n)) && state_q == NABC_ST_FETCH)
    else $error("compare const second word wrong");
  // Add with carry writes the five-bit sum into carry and work
  a_add_with_cy: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH && ins_word == OP_ADD_MEM_CY |=>
    {regs_q.carry, regs_q.work} ==
      5'({1'b0, $past(regs_q.work)} + $past(mem_op) + $past(regs_q.carry)))
    else $error("add with carry wrong");
  // Add immediate keeps carry and skips unless the sum overflows
  a_add_imm: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH && ins_word[9:4] == GRP_ADD_IMM |=>
    regs_q.work == 4'($past(regs_q.work) + $past(imm_n)) && $stable(regs_q.carry) &&
    skip_q == (5'({1'b0, $past(regs_q.work)} + $past(imm_n)) < 5'h10))
    else $error("add immediate wrong");
  // Logic words change only the work register
  a_and_mem: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH && ins_word == OP_AND_MEM |=>
    regs_q.work == ($past(regs_q.work) & $past(mem_op)) && $stable(regs_q.carry))
    else $error("and memory wrong");
  a_or_mem: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH && ins_word == OP_OR_MEM |=>
    regs_q.work == ($past(regs_q.work) | $past(mem_op)) && $stable(regs_q.carry))
    else $error("or memory wrong");
  // Carry words touch the carry flag alone
  a_set_cy: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH && ins_word == OP_SET_CY |=>
    regs_q.carry && $stable(regs_q.work) && !mem_wr.we)
    else $error("set carry wrong");
  a_clr_cy: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH && ins_word == OP_CLR_CY |=>
    !regs_q.carry && $stable(regs_q.work) && !mem_wr.we)
    else $error("clear carry wrong");
  // Bit test skips on a clear bit of the pointed nibble
  a_bit_skip: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH && ins_word[9:2] == GRP_SKIP_BIT |=>
    skip_q == !$past(mem_op[bit_j]) && !mem_wr.we)
    else $error("bit test skip wrong");
  // Bit writes leave the unselected bits as they were read
  a_bit_others: assert property (@(posedge clk_sys) disable iff (reset)
    exec && state_q == NABC_ST_FETCH &&
    (ins_word[9:2] == GRP_SET_BIT || ins_word[9:2] == GRP_CLR_BIT) |=>
    ((mem_wr.data ^ $past(mem_op)) & ~(4'h1 << $past(bit_j))) == 4'h0)
    else $error("bit write disturbed other bits");
  // Only an executed bit word may raise the write strobe
  a_wr_source: assert property (@(posedge clk_sys) disable iff (reset)
    mem_wr.we |-> $past(exec && state_q == NABC_ST_FETCH &&
      (ins_word[9:2] == GRP_SET_BIT || ins_word[9:2] == GRP_CLR_BIT)))
    else $error("memory write without bit word");
endmodule

// ---- nabc_pkg.sv ----
// Constants and carriers for the nibble ALU, bit and compare executor
package nabc_pkg;
  localparam int NIB_W = 4;
  localparam int INS_W = 10;
  // Full opcodes
  localparam logic [9:0] OP_ADD_MEM     = 10'h00a;
  localparam logic [9:0] OP_ADD_MEM_CY  = 10'h00b;
  localparam logic [9:0] OP_AND_MEM     = 10'h018;
  localparam logic [9:0] OP_OR_MEM      = 10'h019;
  localparam logic [9:0] OP_SET_CY      = 10'h007;
  localparam logic [9:0] OP_CLR_CY      = 10'h006;
  localparam logic [9:0] OP_SKIP_CY_CLR = 10'h02f;
  localparam logic [9:0] OP_CPL_WORK    = 10'h01c;
  localparam logic [9:0] OP_ROT_RIGHT   = 10'h01d;
  localparam logic [9:0] OP_SKIP_EQ_MEM = 10'h026;
  localparam logic [9:0] OP_SKIP_EQ_K1  = 10'h025;
  // Opcode groups matched on upper bits; immediate or bit index below
  localparam logic [5:0] GRP_ADD_IMM    = 6'h06;
  localparam logic [5:0] GRP_EQ_K2      = 6'h07;
  localparam logic [7:0] GRP_SET_BIT    = 8'h17;
  localparam logic [7:0] GRP_CLR_BIT    = 8'h13;
  localparam logic [7:0] GRP_SKIP_BIT   = 8'h08;
  localparam logic       CY_RESET       = 1'b0;
  localparam logic [3:0] WORK_RESET     = 4'h0;
  // State the executor writes back each cycle
  typedef struct packed {
    logic [3:0] work;
    logic       carry;
  } nabc_regs_s;
  // Memory write request to the pointed nibble
  typedef struct packed {
    logic       we;
    logic [3:0] data;
  } nabc_mem_wr_s;
  typedef enum logic [0:0] {
    NABC_ST_FETCH  = 1'b0,
    NABC_ST_SECOND = 1'b1
  } nabc_state_e;
endpackage

// ---- nabc_adder.sv ----
// Four-bit adder with carry in and carry out
`timescale 1ns/1ps
module nabc_adder
  import nabc_pkg::*;
#(
  parameter int W = NIB_W
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         cin,
  output logic      [W-1:0] sum,
  output logic              cout
);
  logic [W:0] full; // Sum including carry out
  // One extra bit carries the overflow
  always_comb begin
    full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
    sum  = full[W-1:0];
    cout = full[W];
  end
endmodule

// ---- nabc_ram_model.sv ----
// Behavioural model of the data RAM cell under the data pointer
`timescale 1ns/1ps
module nabc_ram_model
  import nabc_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         load,      // Bench preset of the cell
  input  wire logic [3:0]   load_val,  // Preset value
  input  wire nabc_mem_wr_s mem_wr,    // Write-back from the executor
  output logic      [3:0]   mem_rdata  // Combinational read of the cell
);
  logic [3:0] cell_q;  // Pointer never moves here, so one cell stands in for RAM
  // Write-back lands in the very cell that was read; preset wins over a write
  always_ff @(posedge clk_sys) begin
    if (load) begin
      cell_q <= load_val;
    end else if (mem_wr.we) begin
      cell_q <= mem_wr.data;
    end
  end
  assign mem_rdata = cell_q;
endmodule

// ---- nibble_alu_bit_compare_exec_test.sv ----
// Self-checking bench for the nibble ALU, bit and compare executor
`timescale 1ns/1ps
module nibble_alu_bit_compare_exec_test;
  import nabc_pkg::*;
  logic         clk_sys, reset, ins_valid, load;  // Clock, reset and strobes
  logic [9:0]   ins_word;                         // Word offered to the executor
  logic [3:0]   mem_rdata, load_val;              // RAM read and preset
  nabc_regs_s   regs;                             // Work register and carry
  nabc_mem_wr_s mem_wr;                           // Bit write-back
  logic         skip_next;                        // Skip request
  int           err_count, checks_done;           // Verdict counters
  nabc_exec nabc_exec_i (.clk_sys(clk_sys), .reset(reset), .ins_valid(ins_valid),
    .ins_word(ins_word), .mem_rdata(mem_rdata), .regs(regs), .mem_wr(mem_wr),
    .skip_next(skip_next));
  nabc_ram_model nabc_ram_model_i (.clk_sys(clk_sys), .load(load), .load_val(load_val),
    .mem_wr(mem_wr), .mem_rdata(mem_rdata));
  // Nibble comparison
  task automatic cmp_nib(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t nibble %h expected %h", $time, got, exp);
    end
  endtask
  // Single-bit comparison
  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  // Preset the RAM cell; load drops at the edge that writes it
  task automatic put(input logic [3:0] v);
    @(posedge clk_sys);
    load <= 1'b1;
    load_val <= v;
    @(posedge clk_sys);
    load <= 1'b0;
  endtask
  // One valid word, then check work, carry and skip once the answer has landed
  task automatic run(input logic [9:0] w, input logic [3:0] ew, input logic ec, es);
    @(posedge clk_sys);
    ins_valid <= 1'b1;
    ins_word <= w;
    @(posedge clk_sys);
    ins_valid <= 1'b0;
    #1;
    cmp_nib(regs.work, ew);
    cmp_bit(regs.carry, ec);
    cmp_bit(skip_next, es);
  endtask
  // Adds, carry set/clear, add immediate with and without overflow
  task automatic t_arith();
    put(4'h9);
    run(10'h00a, 4'h9, 1'b0, 1'b0);
    run(10'h007, 4'h9, 1'b1, 1'b0);
    put(4'h8);
    run(10'h00b, 4'h2, 1'b1, 1'b0);
    run(10'h006, 4'h2, 1'b0, 1'b0);
    run(10'h06f, 4'h1, 1'b0, 1'b0);
    run(10'h063, 4'h4, 1'b0, 1'b1);
    run(10'h007, 4'h4, 1'b0, 1'b0);
  endtask
  // Logic, complement, rotate and carry test; a skipped word must not set carry
  task automatic t_logic();
    put(4'h6);
    run(10'h018, 4'h4, 1'b0, 1'b0);
    put(4'h3);
    run(10'h019, 4'h7, 1'b0, 1'b0);
    run(10'h01c, 4'h8, 1'b0, 1'b0);
    run(10'h01d, 4'h4, 1'b0, 1'b0);
    run(10'h007, 4'h4, 1'b1, 1'b0);
    run(10'h01d, 4'ha, 1'b0, 1'b0);
    run(10'h02f, 4'ha, 1'b0, 1'b1);
    run(10'h007, 4'ha, 1'b0, 1'b0);
    run(10'h007, 4'ha, 1'b1, 1'b0);
    run(10'h02f, 4'ha, 1'b1, 1'b0);
  endtask
  // Every bit index: set, test set and clear bits, clear
  task automatic t_bits();
    for (int j = 0; j < 4; j++) begin
      put(4'h0);
      run({8'h17, j[1:0]}, 4'ha, 1'b1, 1'b0);
      cmp_bit(mem_wr.we, 1'b1);
      cmp_nib(mem_wr.data, 4'(1 << j));
      run({8'h08, j[1:0]}, 4'ha, 1'b1, 1'b0);
      run({8'h08, 2'(j + 1)}, 4'ha, 1'b1, 1'b1);
      run(10'h006, 4'ha, 1'b1, 1'b0);
      put(4'hf);
      run({8'h13, j[1:0]}, 4'ha, 1'b1, 1'b0);
      cmp_bit(mem_wr.we, 1'b1);
      cmp_nib(mem_wr.data, 4'hf ^ 4'(1 << j));
    end
  endtask
  // Compare with memory and the two-word compare with a constant
  task automatic t_cmp();
    put(4'ha);
    run(10'h026, 4'ha, 1'b1, 1'b1);
    run(10'h006, 4'ha, 1'b1, 1'b0);
    put(4'h5);
    run(10'h026, 4'ha, 1'b1, 1'b0);
    run(10'h025, 4'ha, 1'b1, 1'b0);
    run(10'h07a, 4'ha, 1'b1, 1'b1);
    run(10'h006, 4'ha, 1'b1, 1'b0);
    run(10'h025, 4'ha, 1'b1, 1'b0);
    run(10'h075, 4'ha, 1'b1, 1'b0);
  endtask
  // Back to back words: a bit test right behind a bit set, then a skipped set
  task automatic t_b2b();
    put(4'h0);
    @(posedge clk_sys);
    ins_valid <= 1'b1;
    ins_word <= {8'h17, 2'h2};
    @(posedge clk_sys);
    ins_word <= {8'h08, 2'h2};
    @(posedge clk_sys);
    ins_word <= {8'h08, 2'h1};
    #1;
    cmp_bit(skip_next, 1'b0);
    @(posedge clk_sys);
    ins_word <= {8'h17, 2'h0};
    #1;
    cmp_bit(skip_next, 1'b1);
    @(posedge clk_sys);
    ins_valid <= 1'b0;
    #1;
    cmp_bit(skip_next, 1'b0);
    cmp_bit(mem_wr.we, 1'b0);
    cmp_nib(mem_rdata, 4'h4);
  endtask
  // Counts, verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Reset for three cycles, then the scenarios in order
  initial begin
    {reset, ins_valid, ins_word, load, load_val} = {1'b1, 1'b0, 10'h000, 1'b0, 4'h0};
    err_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    t_arith();
    t_logic();
    t_bits();
    t_cmp();
    t_b2b();
    end_of_test();
  end
  // Watchdog: the run needs well under 1000 cycles, so 20 us means a hang
  initial begin
    #20000;
    err_count++;
    end_of_test();
  end
endmodule
